// *** common/port_cfg_pkg.sv ***
// Contract
// - sixteen pins in two byte-wide ports
// - pins 0..14 selectable analog or digital
// - pin 15 is GPIO only, shares debug data
// - reset gives digital, hi-z, pull-up on
// - analog select kills pull-up and receiver
// - analog pins read back as zero
// - push-pull drives pad from output value
// - open-drain never drives high, floats on one
// - pull-up on when floating, off driving low
// - global pull-up disable kills all pull-ups
// - digital pins read the sensed pad level
// - per-pin drive strength, low by default
// - reference outputs fixed on pins 0, 1, 7
// - oscillator pins 2 and 3 fixed
// - crossbar skips reserved or claimed pins
// - drivers off while crossbar disabled, except pin 15 while the debug link is active
package port_cfg_pkg;
    localparam int NUM_PINS = 16;
    localparam int CFG_PINS = 15;
    localparam int XPIN_W = 4;
    localparam logic [7:0] ADDR_ANALOG_SEL = 8'h00;
    localparam logic [7:0] ADDR_OUT_MODE = 8'h04;
    localparam logic [7:0] ADDR_DRIVE = 8'h08;
    localparam logic [7:0] ADDR_RESERVE = 8'h0c;
    localparam logic [7:0] ADDR_LATCH = 8'h10;
    localparam logic [7:0] ADDR_CTRL = 8'h14;
    localparam logic [7:0] ADDR_PIN_LEVEL = 8'h18;
    localparam logic [7:0] ADDR_XBAR_STAT = 8'h1c;
    localparam logic [14:0] RST_ANALOG_SEL = 15'h7fff;
    localparam logic [15:0] RST_OUT_MODE = 16'h0000;
    localparam logic [15:0] RST_DRIVE = 16'h0000;
    localparam logic [14:0] RST_RESERVE = 15'h0000;
    localparam logic [15:0] RST_LATCH = 16'hffff;
    localparam logic RST_PUD = 1'b0;
    localparam logic RST_XBAR_EN = 1'b0;
    localparam int CTRL_PUD_BIT = 0;
    localparam int CTRL_XBAR_EN_BIT = 1;
    localparam int XSTAT_VALID_BIT = 4;
    localparam int PIN_VREF = 0;
    localparam int PIN_ANALOG_GROUND_REFERENCE = 1;
    localparam int PIN_OSC_IN = 2;
    localparam int PIN_OSC_OUT = 3;
    localparam int PIN_IREF = 7;
    localparam int PIN_DEBUG = 15;
    localparam logic PAD_RST_OUT = 1'b1;
    localparam logic PAD_RST_OE = 1'b0;
    localparam logic PAD_RST_PULL = 1'b1;
    localparam logic PAD_RST_DRIVE = 1'b0;
    localparam logic PAD_RST_RX = 1'b1;
    localparam logic PAD_RST_LEVEL = 1'b0;
endpackage

// *** verilog/port_pad_cell.sv ***
`timescale 1ns/100ps
`default_nettype none
module port_pad_cell
    import port_cfg_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic digital,
    input wire logic push_pull,
    input wire logic drive_hi,
    input wire logic out_val,
    input wire logic drv_allow,
    input wire logic pud,
    input wire logic pad_in,
    output logic pad_out_q,
    output logic pad_oe_q,
    output logic pullup_q,
    output logic drive_hi_q,
    output logic rx_en_q,
    output logic level_q
);
    logic oe_d;
    logic pull_d;

    always_comb begin
        // open drain only ever sinks
        oe_d = drv_allow & (push_pull | ~out_val);
        // a weak pull-up fighting our own low driver only burns current
        pull_d = digital & ~pud & ~(oe_d & ~out_val);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pad_out_q <= PAD_RST_OUT;
            pad_oe_q <= PAD_RST_OE;
            pullup_q <= PAD_RST_PULL;
            drive_hi_q <= PAD_RST_DRIVE;
            rx_en_q <= PAD_RST_RX;
            level_q <= PAD_RST_LEVEL;
        end else begin
            pad_out_q <= out_val;
            pad_oe_q <= oe_d;
            pullup_q <= pull_d;
            drive_hi_q <= drive_hi;
            rx_en_q <= digital;
            level_q <= digital & pad_in;
        end
    end

    property p_od_never_high;
        @(posedge clk) disable iff (!rst_n)
        (!push_pull && out_val) |=> !pad_oe_q;
    endproperty
    a_od_never_high: assert property (p_od_never_high)
        else $error("open-drain pin drove high");

    property p_pull_off_low;
        @(posedge clk) disable iff (!rst_n)
        !(pad_oe_q && !pad_out_q && pullup_q);
    endproperty
    a_pull_off_low: assert property (p_pull_off_low)
        else $error("pull-up on while driving low");
endmodule
`default_nettype wire

// *** verilog/port_io_cell_config.sv ***
`timescale 1ns/100ps
`default_nettype none
module port_io_cell_config
    import port_cfg_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] pad_in,
    output logic [15:0] pad_out,
    output logic [15:0] pad_oe,
    output logic [15:0] pad_pullup_en,
    output logic [15:0] pad_drive_hi,
    output logic [15:0] pad_rx_en,
    output logic [14:0] analog_sw,
    input wire logic [14:0] periph_claim,
    input wire logic [14:0] periph_out,
    input wire logic voltage_reference_out,
    input wire logic analog_ground_reference,
    input wire logic current_reference_out,
    input wire logic ext_osc_en,
    input wire logic debug_link_active,
    input wire logic debug_link_data_pin,
    input wire logic debug_link_data_oe,
    output logic [3:0] xbar_next_pin,
    output logic xbar_next_valid
);
    logic [14:0] pin_analog_digital_select_q;
    logic [15:0] pin_output_mode_select_q;
    logic [15:0] pin_drive_strength_select_q;
    logic [14:0] crossbar_pin_reserve_q;
    logic [15:0] latch_q;
    logic global_pullup_disable_q;
    logic routing_matrix_enable_q;
    logic [15:0] level_q;
    logic [14:0] analog_sw_q;
    logic [3:0] xpin_q;
    logic xvalid_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic [3:0] xpin_d;
    logic xvalid_d;
    logic [31:0] rd_d;
    logic hit_d;
    logic wr_en;
    logic [15:0] digital_v;
    logic [15:0] mode_v;
    logic [15:0] val_v;
    logic [15:0] allow_v;
    logic [15:0] dedicated_v;
    logic [14:0] claim_v;
    logic [14:0] avail_v;

    // write lands at the edge that samples pready with psel and penable
    assign wr_en = psel & penable & pwrite & pready_q;

    always_comb begin
        dedicated_v = '0;
        dedicated_v[PIN_VREF] = voltage_reference_out;
        dedicated_v[PIN_ANALOG_GROUND_REFERENCE] = analog_ground_reference;
        dedicated_v[PIN_IREF] = current_reference_out;
        dedicated_v[PIN_OSC_IN] = ext_osc_en;
        dedicated_v[PIN_OSC_OUT] = ext_osc_en;
    end

    // the top pin has no select bit and is always digital
    always_comb begin
        claim_v = periph_claim & ~crossbar_pin_reserve_q & ~dedicated_v[14:0];
        digital_v = {1'b1, pin_analog_digital_select_q};
        mode_v = pin_output_mode_select_q;
        val_v = latch_q;
        for (int i = 0; i < CFG_PINS; i++) begin
            if (claim_v[i]) begin
                val_v[i] = periph_out[i];
            end
        end
        allow_v = {NUM_PINS{routing_matrix_enable_q}} & ~dedicated_v;
        if (debug_link_active) begin
            // debug link owns the shared pin outright
            val_v[PIN_DEBUG] = debug_link_data_pin;
            mode_v[PIN_DEBUG] = 1'b1;
            allow_v[PIN_DEBUG] = debug_link_data_oe;
        end
    end

    // lowest unreserved, unclaimed, non-dedicated pin is the next crossbar grant
    always_comb begin
        avail_v = ~crossbar_pin_reserve_q & ~periph_claim & ~dedicated_v[14:0];
        xpin_d = '0;
        xvalid_d = 1'b0;
        for (int i = CFG_PINS - 1; i >= 0; i--) begin
            if (avail_v[i]) begin
                xpin_d = XPIN_W'(i);
                xvalid_d = 1'b1;
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_PINS; g++) begin : g_pin
            port_pad_cell u_cell (
                .clk(pclk),
                .rst_n(presetn),
                .digital(digital_v[g]),
                .push_pull(mode_v[g]),
                .drive_hi(pin_drive_strength_select_q[g]),
                .out_val(val_v[g]),
                .drv_allow(allow_v[g]),
                .pud(global_pullup_disable_q),
                .pad_in(pad_in[g]),
                .pad_out_q(pad_out[g]),
                .pad_oe_q(pad_oe[g]),
                .pullup_q(pad_pullup_en[g]),
                .drive_hi_q(pad_drive_hi[g]),
                .rx_en_q(pad_rx_en[g]),
                .level_q(level_q[g])
            );
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_analog_digital_select_q <= RST_ANALOG_SEL;
            pin_output_mode_select_q <= RST_OUT_MODE;
            pin_drive_strength_select_q <= RST_DRIVE;
            crossbar_pin_reserve_q <= RST_RESERVE;
            latch_q <= RST_LATCH;
            global_pullup_disable_q <= RST_PUD;
            routing_matrix_enable_q <= RST_XBAR_EN;
        end else if (wr_en) begin
            case (paddr)
                ADDR_ANALOG_SEL: pin_analog_digital_select_q <= pwdata[14:0];
                ADDR_OUT_MODE: pin_output_mode_select_q <= pwdata[15:0];
                ADDR_DRIVE: pin_drive_strength_select_q <= pwdata[15:0];
                ADDR_RESERVE: crossbar_pin_reserve_q <= pwdata[14:0];
                ADDR_LATCH: latch_q <= pwdata[15:0];
                ADDR_CTRL: begin
                    global_pullup_disable_q <= pwdata[CTRL_PUD_BIT];
                    routing_matrix_enable_q <= pwdata[CTRL_XBAR_EN_BIT];
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            analog_sw_q <= '0;
            xpin_q <= '0;
            xvalid_q <= 1'b0;
        end else begin
            analog_sw_q <= ~pin_analog_digital_select_q;
            xpin_q <= xpin_d;
            xvalid_q <= xvalid_d;
        end
    end

    always_comb begin
        rd_d = '0;
        hit_d = 1'b1;
        case (paddr)
            ADDR_ANALOG_SEL: rd_d[15:0] = digital_v;
            ADDR_OUT_MODE: rd_d[15:0] = pin_output_mode_select_q;
            ADDR_DRIVE: rd_d[15:0] = pin_drive_strength_select_q;
            ADDR_RESERVE: rd_d[14:0] = crossbar_pin_reserve_q;
            ADDR_LATCH: rd_d[15:0] = latch_q;
            ADDR_CTRL: begin
                rd_d[CTRL_PUD_BIT] = global_pullup_disable_q;
                rd_d[CTRL_XBAR_EN_BIT] = routing_matrix_enable_q;
            end
            ADDR_PIN_LEVEL: rd_d[15:0] = level_q;
            ADDR_XBAR_STAT: begin
                rd_d[XPIN_W-1:0] = xpin_q;
                rd_d[XSTAT_VALID_BIT] = xvalid_q;
            end
            default: hit_d = 1'b0;
        endcase
    end

    // zero wait states: the answer is ready in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            prdata_q <= '0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= psel & ~penable;
            if (psel && !penable) begin
                prdata_q <= pwrite ? 32'h0000_0000 : rd_d;
                pslverr_q <= ~hit_d;
            end else begin
                pslverr_q <= 1'b0;
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign analog_sw = analog_sw_q;
    assign xbar_next_pin = xpin_q;
    assign xbar_next_valid = xvalid_q;

    property p_reset_cells;
        @(posedge pclk) disable iff (!presetn)
        ($past(presetn) == 1'b0) |-> (pad_oe == '0 && pad_pullup_en == '1 && pad_rx_en == '1);
    endproperty
    a_reset_cells: assert property (p_reset_cells)
        else $error("pads not hi-z with pull-ups after reset");

    property p_analog_quiet;
        @(posedge pclk) disable iff (!presetn)
        1'b1 |=> ((pad_pullup_en | pad_rx_en) & ~$past(digital_v)) == '0;
    endproperty
    a_analog_quiet: assert property (p_analog_quiet)
        else $error("analog pin kept pull-up or receiver");

    property p_analog_reads_zero;
        @(posedge pclk) disable iff (!presetn)
        presetn |=> (level_q == ($past(pad_in) & $past(digital_v)));
    endproperty
    a_analog_reads_zero: assert property (p_analog_reads_zero)
        else $error("pin level read-back wrong");

    property p_push_pull_drives;
        @(posedge pclk) disable iff (!presetn)
        (routing_matrix_enable_q && mode_v[4] && !dedicated_v[4]) |=> (pad_oe[4] && pad_out[4] == $past(val_v[4]));
    endproperty
    a_push_pull_drives: assert property (p_push_pull_drives)
        else $error("push-pull pin not driven from its value");

    property p_pud_all_off;
        @(posedge pclk) disable iff (!presetn)
        global_pullup_disable_q |=> pad_pullup_en == '0;
    endproperty
    a_pud_all_off: assert property (p_pud_all_off)
        else $error("pull-up on with global disable set");

    property p_drive_follows;
        @(posedge pclk) disable iff (!presetn)
        1'b1 |=> pad_drive_hi == $past(pin_drive_strength_select_q);
    endproperty
    a_drive_follows: assert property (p_drive_follows)
        else $error("drive strength not applied");

    property p_fixed_pins;
        @(posedge pclk) disable iff (!presetn)
        (voltage_reference_out || ext_osc_en) |=> !(pad_oe[PIN_VREF] && $past(voltage_reference_out))
            && !(pad_oe[PIN_OSC_IN] && $past(ext_osc_en));
    endproperty
    a_fixed_pins: assert property (p_fixed_pins)
        else $error("dedicated analog pin driven");

    property p_skip_reserved;
        @(posedge pclk) disable iff (!presetn)
        (presetn && xvalid_d) |=> xvalid_q && !$past(crossbar_pin_reserve_q[xpin_d])
            && !$past(periph_claim[xpin_d]);
    endproperty
    a_skip_reserved: assert property (p_skip_reserved)
        else $error("crossbar picked a reserved or claimed pin");

    property p_xbar_off;
        @(posedge pclk) disable iff (!presetn)
        (!routing_matrix_enable_q && !debug_link_active) [*2] |-> pad_oe == '0;
    endproperty
    a_xbar_off: assert property (p_xbar_off)
        else $error("driver on while crossbar disabled");

    property p_write_reaches_pad;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == ADDR_ANALOG_SEL) |=> ##1 pad_rx_en[14:0] == $past(pwdata[14:0], 2);
    endproperty
    a_write_reaches_pad: assert property (p_write_reaches_pad)
        else $error("configuration write not on pad next cycle");

    property p_debug_pin_digital;
        @(posedge pclk) disable iff (!presetn)
        1'b1 |=> pad_rx_en[PIN_DEBUG];
    endproperty
    a_debug_pin_digital: assert property (p_debug_pin_digital)
        else $error("shared debug pin left digital mode");
endmodule
`default_nettype wire

// *** verif/pad_world_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module pad_world_model (
    input wire logic clk,
    input wire logic [15:0] oe,
    input wire logic [15:0] drv,
    input wire logic [15:0] pull,
    input wire logic [15:0] ext_en,
    input wire logic [15:0] ext_val,
    output logic [15:0] level
);
    // a pad nobody drives or pulls has no defined level, so it wanders every cycle
    logic [15:0] float_q = 16'h5555;
    always_ff @(posedge clk) begin
        float_q <= ~float_q;
    end
    always_comb begin
        for (int n = 0; n < 16; n++) begin
            if (oe[n])
                level[n] = drv[n];
            else if (ext_en[n])
                level[n] = ext_val[n];
            else if (pull[n])
                level[n] = 1'b1;
            else
                level[n] = float_q[n];
        end
    end
endmodule
`default_nettype wire

// *** verif/port_io_cell_config_tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module port_io_cell_config_tb_top import port_cfg_pkg::*;;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err_s;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdata_s;
    logic [15:0] pad_in, pad_out, pad_oe, pad_pullup_en, pad_drive_hi, pad_rx_en;
    logic [15:0] ext_en, ext_val;
    logic [14:0] analog_sw, claim;
    logic [3:0] xbar_next_pin;
    logic xbar_next_valid, vref_on, osc_on, dbg_act, dbg_data, dbg_oe;
    int fails, total_checks;

    port_io_cell_config port_io_cell_config_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
        .pad_pullup_en(pad_pullup_en), .pad_drive_hi(pad_drive_hi), .pad_rx_en(pad_rx_en),
        .analog_sw(analog_sw), .periph_claim(claim), .periph_out(15'h0000),
        .voltage_reference_out(vref_on), .analog_ground_reference(vref_on),
        .current_reference_out(vref_on), .ext_osc_en(osc_on), .debug_link_active(dbg_act),
        .debug_link_data_pin(dbg_data), .debug_link_data_oe(dbg_oe),
        .xbar_next_pin(xbar_next_pin), .xbar_next_valid(xbar_next_valid));

    pad_world_model pad_world_model_i (.clk(pclk), .oe(pad_oe), .drv(pad_out),
        .pull(pad_pullup_en), .ext_en(ext_en), .ext_val(ext_val), .level(pad_in));

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    task end_of_test;
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        if (n >= 40)
            fails++;
        rdata_s = prdata;
        err_s = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rd(input logic [7:0] a, input logic [31:0] exp, input string name);
        apb(1'b0, a, 32'h0);
        chk(name, exp, rdata_s);
    endtask

    // one edge only: pads must follow a register write on the very next cycle
    task settle;
        @(posedge pclk);
        #1;
    endtask

    task t_reset;
        chk("oe", 32'h0, 32'(pad_oe));
        chk("out", 32'hffff, 32'(pad_out));
        chk("pull", 32'hffff, 32'(pad_pullup_en));
        chk("rx", 32'hffff, 32'(pad_rx_en));
        chk("drive", 32'h0, 32'(pad_drive_hi));
        rd(ADDR_ANALOG_SEL, 32'hffff, "sel");
        rd(ADDR_OUT_MODE, 32'h0, "mode");
        rd(ADDR_XBAR_STAT, 32'h10, "xstat");
        $display("test reset done");
    endtask

    task t_pushpull;
        apb(1'b1, ADDR_OUT_MODE, 32'h13);
        apb(1'b1, ADDR_LATCH, 32'hfffe);
        settle;
        chk("oe_off", 32'h0, 32'(pad_oe));
        apb(1'b1, ADDR_CTRL, 32'h2);
        settle;
        chk("oe_pp", 32'h13, 32'(pad_oe));
        chk("out_pp", 32'hfffe, 32'(pad_out));
        chk("pull_pp", 32'hfffe, 32'(pad_pullup_en));
        rd(ADDR_PIN_LEVEL, 32'hfffe, "level");
        $display("test push-pull done");
    endtask

    task t_opendrain;
        apb(1'b1, ADDR_OUT_MODE, 32'h0);
        apb(1'b1, ADDR_LATCH, 32'hfffd);
        settle;
        chk("oe_od", 32'h2, 32'(pad_oe));
        chk("out_od", 32'hfffd, 32'(pad_out));
        chk("pull_od", 32'hfffd, 32'(pad_pullup_en));
        apb(1'b1, ADDR_CTRL, 32'h3);
        settle;
        chk("pull_off", 32'h0, 32'(pad_pullup_en));
        apb(1'b1, ADDR_CTRL, 32'h2);
        $display("test open-drain done");
    endtask

    task t_analog;
        ext_en <= 16'h0018;
        ext_val <= 16'h0008;
        apb(1'b1, ADDR_LATCH, 32'hffff);
        apb(1'b1, ADDR_RESERVE, 32'h8);
        apb(1'b1, ADDR_ANALOG_SEL, 32'h7ff7);
        settle;
        chk("asw", 32'h8, 32'(analog_sw));
        chk("rx_an", 32'hfff7, 32'(pad_rx_en));
        chk("pull_an", 32'hfff7, 32'(pad_pullup_en));
        rd(ADDR_PIN_LEVEL, 32'hffe7, "level_an");
        apb(1'b1, ADDR_ANALOG_SEL, 32'h7fff);
        ext_en <= 16'h0000;
        $display("test analog done");
    endtask

    task t_drive_xbar;
        apb(1'b1, ADDR_DRIVE, 32'h8001);
        settle;
        chk("drv", 32'h8001, 32'(pad_drive_hi));
        apb(1'b1, ADDR_RESERVE, 32'h7);
        settle;
        chk("next", 32'h3, 32'(xbar_next_pin));
        rd(ADDR_XBAR_STAT, 32'h13, "xstat_skip");
        apb(1'b1, ADDR_RESERVE, 32'h0);
        // all dedicated pins plus one claimed pin: the grant has to move past five pins
        vref_on <= 1'b1;
        osc_on <= 1'b1;
        claim <= 15'h0010;
        apb(1'b1, ADDR_OUT_MODE, 32'h8f);
        settle;
        chk("oe_vref", 32'h10, 32'(pad_oe));
        chk("out_claim", 32'hffef, 32'(pad_out));
        chk("valid", 32'h1, 32'(xbar_next_valid));
        rd(ADDR_XBAR_STAT, 32'h15, "xstat_vref");
        vref_on <= 1'b0;
        osc_on <= 1'b0;
        claim <= 15'h0000;
        $display("test drive and crossbar done");
    endtask

    task t_err_debug;
        apb(1'b1, 8'h20, 32'h0);
        chk("err_w", 32'h1, 32'(err_s));
        rd(8'h20, 32'h0, "err_data");
        chk("err_r", 32'h1, 32'(err_s));
        rd(ADDR_ANALOG_SEL, 32'hffff, "sel_kept");
        apb(1'b1, ADDR_CTRL, 32'h0);
        dbg_act <= 1'b1;
        dbg_oe <= 1'b1;
        dbg_data <= 1'b0;
        settle;
        chk("oe_dbg", 32'h8000, 32'(pad_oe));
        chk("out_dbg", 32'h0, 32'(pad_out[15]));
        @(posedge pclk);
        dbg_act <= 1'b0;
        $display("test error and debug done");
    endtask

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        ext_en = 16'h0000;
        ext_val = 16'h0000;
        vref_on = 1'b0;
        osc_on = 1'b0;
        claim = 15'h0000;
        dbg_act = 1'b0;
        dbg_data = 1'b0;
        dbg_oe = 1'b0;
        fails = 0;
        total_checks = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        settle;
        t_reset;
        t_pushpull;
        t_opendrain;
        t_analog;
        t_drive_xbar;
        t_err_debug;
        end_of_test;
    end

    initial begin
        repeat (5000) @(posedge pclk);
        fails++;
        end_of_test;
    end
endmodule
`default_nettype wire
